// *** src/pdrc_map.vh ***
// pdrc_map.vh: register offsets, codes, reset values and timing for the power/reset controller
// assumes inclusion by the controller only; definitions only
`ifndef PDRC_MAP_VH
`define PDRC_MAP_VH

`define PDRC_PWR_MODE_OFS     8'h87
`define PDRC_PWR_MODE_RST     8'h00
`define PDRC_MODE_IDLE        8'h01
`define PDRC_MODE_STOP        8'h03
`define PDRC_RST_CFG_OFS      8'h88
`define PDRC_STAT_OFS         8'h89
`define PDRC_WAKE_SEL_OFS     8'h8A
`define PDRC_RST_CFG_RST      8'h00
`define PDRC_PC_RST           16'h0000
`define PDRC_ACC_RST          8'h00
`define PDRC_SP_RST           8'h07
`define PDRC_FILT_NS          2000
`define PDRC_CLK_MHZ          40
`define PDRC_FILT_CYC         ((`PDRC_FILT_NS * `PDRC_CLK_MHZ + 999) / 1000)
`define PDRC_POR_CYC          16
`define PDRC_STAT_RUN         2'h0
`define PDRC_STAT_IDLE        2'h1
`define PDRC_STAT_STOP        2'h2
`define PDRC_STAT_WAKE        2'h3

`endif

// *** src/pdrc_ctrl.v ***
// pdrc_ctrl.v: power-down mode control and reset source combining for an 8-bit controller
// assumes synchronous inputs from the cpu core, interrupt logic and the reset pin pad
// How it works
// - writing 01h to the mode register enters idle and halts the cpu.
// - writing 03h to the mode register enters stop.
// - any other mode value keeps normal running.
// - the mode register clears itself when the cpu resumes: on release from idle, or after the stabilisation delay from stop.
// - in idle oscillators and peripherals keep running, only the cpu halts.
// - idle ends on any reset or enabled interrupt; software enables it beforehand.
// - a reset ending a power-down reinitialises all registers.
// - stop freezes the selected oscillator, system clock and peripheral clock.
// - stop keeps ram and register contents unchanged.
// - a running sub clock keeps the watch timer and display going in stop.
// - stop wake-up starts the interval timer as stabilisation delay.
// - only listed sources release stop: reset, event timers, serial, ext irq, watch, watchdog.
// - with global enable set, an enabled interrupt wakes and vectors.
// - with global enable clear, an enabled interrupt still wakes stop.
// - in stop general timers halt unless in event counter mode.
// - in stop serial units run only on an external clock.
// - in stop interval timer, converter and tone stop; watchdog unless rc-clocked.
// - reset loads pc 0000h, accumulator 00h, stack 07h, peripheral clock on.
// - five reset sources: pin, power-on, watchdog, low voltage, debugger.
// - low pulses on the reset input shorter than about 2us are ignored.
// - an internal reset is generated at power rise.
`timescale 1ns/1ps
`include "pdrc_map.vh"

module pdrc_ctrl #(
  parameter FILT_CYC = `PDRC_FILT_CYC,
  parameter POR_CYC  = `PDRC_POR_CYC
) (
  // clock and power-up reset
  input  wire        clk_i,
  input  wire        rst_b_i,
  // register port
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  // reset sources
  input  wire        external_reset_pin_n_i,
  input  wire        watchdog_overflow_i,
  input  wire        watchdog_enable_bit_i,
  input  wire        low_voltage_detect_i,
  input  wire        low_voltage_reset_enable_bit_i,
  input  wire        on_chip_debugger_reset_i,
  // interrupts
  input  wire [7:0]  irq_pending_i,
  input  wire [7:0]  irq_enable_i,
  input  wire        global_interrupt_enable_i,
  // peripheral configuration
  input  wire        sub_clock_running_i,
  input  wire [4:0]  timer_event_mode_i,
  input  wire        serial_ext_clk_i,
  input  wire [1:0]  universal_serial_units_ext_clk_i,
  input  wire        watchdog_rc_oscillator_sel_i,
  input  wire        interval_timer_ovf_i,
  // cpu and system outputs
  output wire        cpu_halt_o,
  output reg         sys_reset_o,
  output reg  [15:0] pc_reset_val_o,
  output reg  [7:0]  acc_reset_val_o,
  output reg  [7:0]  sp_reset_val_o,
  output reg         irq_vector_o,
  output reg         resume_next_o,
  // clock and peripheral gating
  output wire        osc_run_o,
  output wire        sys_clk_en_o,
  output wire        periph_clk_en_o,
  output wire        watch_timer_en_o,
  output wire        display_en_o,
  output wire [4:0]  timer_run_o,
  output wire        serial_run_o,
  output wire [1:0]  universal_serial_units_run_o,
  output wire        interval_timer_run_o,
  output wire        converter_run_o,
  output wire        tone_output_unit_run_o,
  output wire        watchdog_timer_run_o,
  output reg         stab_start_o
);

  localparam ST_RUN  = 2'h0;
  localparam ST_IDLE = 2'h1;
  localparam ST_STOP = 2'h2;
  localparam ST_WAKE = 2'h3;

  reg  [7:0]  pwr_mode_q;
  reg  [7:0]  wake_sel_q;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [15:0] filt_cnt_q;
  reg         pin_rst_q;
  reg  [15:0] por_cnt_q;
  reg  [4:0]  src_q;
  wire        int_reset;
  wire        wake_irq;
  wire        stop_wake;
  wire        in_stop;

  // power-on reset stretch: held after release so the core sees a clean reset
  // power-up reset
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
      por_cnt_q <= 16'h0000;
    else if (por_cnt_q != POR_CYC[15:0])
      por_cnt_q <= por_cnt_q + 16'h0001;
  end

  // pin filter: a low must persist FILT_CYC cycles; shorter dips are noise
  // pin noise filter
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      filt_cnt_q <= 16'h0000;
      pin_rst_q  <= 1'b0;
    end
    else if (external_reset_pin_n_i)
    begin
      filt_cnt_q <= 16'h0000;
      pin_rst_q  <= 1'b0;
    end
    else if (filt_cnt_q >= FILT_CYC[15:0] - 16'h0001)
      pin_rst_q  <= 1'b1;
    else
      filt_cnt_q <= filt_cnt_q + 16'h0001;
  end

  assign int_reset = (por_cnt_q != POR_CYC[15:0]) | pin_rst_q |
                     (watchdog_overflow_i & watchdog_enable_bit_i) |
                     (low_voltage_detect_i & low_voltage_reset_enable_bit_i) |
                     on_chip_debugger_reset_i;

  assign wake_irq  = |(irq_pending_i & irq_enable_i);
  assign stop_wake = |(irq_pending_i & irq_enable_i & wake_sel_q);

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
        if (pwr_mode_q == `PDRC_MODE_IDLE)
          state_d = ST_IDLE;
        else if (pwr_mode_q == `PDRC_MODE_STOP)
          state_d = ST_STOP;
      ST_IDLE:
        if (wake_irq)
          state_d = ST_RUN;
      ST_STOP:
        if (stop_wake)
          state_d = ST_WAKE;
      ST_WAKE:
        if (interval_timer_ovf_i)
          state_d = ST_RUN;
      default:
        state_d = ST_RUN;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (!rst_b_i || int_reset)
    begin
      state_q         <= ST_RUN;
      pwr_mode_q      <= `PDRC_PWR_MODE_RST;
      wake_sel_q      <= 8'hFF;
      sys_reset_o     <= 1'b1;
      pc_reset_val_o  <= `PDRC_PC_RST;
      acc_reset_val_o <= `PDRC_ACC_RST;
      sp_reset_val_o  <= `PDRC_SP_RST;
      irq_vector_o    <= 1'b0;
      resume_next_o   <= 1'b0;
      stab_start_o    <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      sys_reset_o   <= 1'b0;
      irq_vector_o  <= 1'b0;
      resume_next_o <= 1'b0;
      stab_start_o  <= (state_q == ST_STOP) && (state_d == ST_WAKE);
      if (state_q != ST_RUN && state_d == ST_RUN)
      begin
        pwr_mode_q <= `PDRC_PWR_MODE_RST;
        irq_vector_o  <= global_interrupt_enable_i;
        resume_next_o <= ~global_interrupt_enable_i;
      end
      else if (reg_wr_i && state_q == ST_RUN)
      begin
        if (reg_addr_i == `PDRC_PWR_MODE_OFS)
          pwr_mode_q <= reg_wdata_i;
        if (reg_addr_i == `PDRC_WAKE_SEL_OFS)
          wake_sel_q <= reg_wdata_i;
      end
    end
  end

  // read data in the cycle after the strobe; unmapped reads zero
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      case (reg_addr_i)
        `PDRC_PWR_MODE_OFS: reg_rdata_o <= pwr_mode_q;
        `PDRC_STAT_OFS:     reg_rdata_o <= {2'h0, src_q[4:1], state_q};
        `PDRC_WAKE_SEL_OFS: reg_rdata_o <= wake_sel_q;
        default:            reg_rdata_o <= 8'h00;
      endcase
    else
      reg_rdata_o <= 8'h00;
  end

  // latched reset cause, shown in status bits 5:2 (pin, watchdog, low volt, debugger)
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
      src_q <= 5'h01;
    else if (int_reset)
      src_q <= {on_chip_debugger_reset_i,
                low_voltage_detect_i & low_voltage_reset_enable_bit_i,
                watchdog_overflow_i & watchdog_enable_bit_i, pin_rst_q, 1'b0};
  end

  assign in_stop = (state_q == ST_STOP);

  assign cpu_halt_o      = (state_q != ST_RUN);
  pdrc_gate #(.WIDTH(1)) osc_gate_i (
    .stop_i (in_stop),
    .keep_i (1'b0),
    .run_o  (osc_run_o)
  );

  pdrc_gate #(.WIDTH(1)) sys_clk_gate_i (
    .stop_i (in_stop),
    .keep_i (1'b0),
    .run_o  (sys_clk_en_o)
  );

  pdrc_gate #(.WIDTH(1)) periph_clk_gate_i (
    .stop_i (in_stop),
    .keep_i (1'b0),
    .run_o  (periph_clk_en_o)
  );

  pdrc_gate #(.WIDTH(1)) watch_gate_i (
    .stop_i (in_stop),
    .keep_i (sub_clock_running_i),
    .run_o  (watch_timer_en_o)
  );

  pdrc_gate #(.WIDTH(1)) display_gate_i (
    .stop_i (in_stop),
    .keep_i (sub_clock_running_i),
    .run_o  (display_en_o)
  );

  pdrc_gate #(.WIDTH(5)) timer_gate_i (
    .stop_i (in_stop),
    .keep_i (timer_event_mode_i),
    .run_o  (timer_run_o)
  );

  pdrc_gate #(.WIDTH(1)) serial_gate_i (
    .stop_i (in_stop),
    .keep_i (serial_ext_clk_i),
    .run_o  (serial_run_o)
  );

  pdrc_gate #(.WIDTH(2)) usu_gate_i (
    .stop_i (in_stop),
    .keep_i (universal_serial_units_ext_clk_i),
    .run_o  (universal_serial_units_run_o)
  );

  pdrc_gate #(.WIDTH(1)) interval_gate_i (
    .stop_i (in_stop),
    .keep_i (1'b0),
    .run_o  (interval_timer_run_o)
  );

  pdrc_gate #(.WIDTH(1)) converter_gate_i (
    .stop_i (in_stop),
    .keep_i (1'b0),
    .run_o  (converter_run_o)
  );

  pdrc_gate #(.WIDTH(1)) tone_gate_i (
    .stop_i (in_stop),
    .keep_i (1'b0),
    .run_o  (tone_output_unit_run_o)
  );

  // rc-clocked watchdog has its own oscillator, so it may outlive the system clock
  pdrc_gate #(.WIDTH(1)) watchdog_gate_i (
    .stop_i (in_stop),
    .keep_i (watchdog_rc_oscillator_sel_i),
    .run_o  (watchdog_timer_run_o)
  );

endmodule

// one gated run enable: all ones while running, the keep-alive input while stopped
module pdrc_gate #(
  parameter WIDTH = 1
) (
  // stop state and keep-alive condition
  input  wire             stop_i,
  input  wire [WIDTH-1:0] keep_i,
  // resulting run enable
  output wire [WIDTH-1:0] run_o
);

  assign run_o = stop_i ? keep_i : {WIDTH{1'b1}};

endmodule

// *** tb/pdrc_checker.sv ***
// pdrc_checker.sv: port-level assertions for the power/reset controller
// assumes binding onto pdrc_ctrl; one clock, sync active-low reset
`timescale 1ns/1ps
module pdrc_checker (
  // clock, reset, register port
  input wire        clk_i, rst_b_i, reg_wr_i,
  input wire [7:0]  reg_addr_i, reg_wdata_i,
  // observed state and gating
  input wire        cpu_halt_o, sys_reset_o, osc_run_o, sys_clk_en_o, periph_clk_en_o,
  input wire        interval_timer_run_o, converter_run_o, tone_output_unit_run_o,
  input wire        watch_timer_en_o, display_en_o, sub_clock_running_i, stab_start_o,
  input wire        watchdog_timer_run_o, watchdog_rc_oscillator_sel_i,
  input wire [4:0]  timer_run_o, timer_event_mode_i,
  input wire [15:0] pc_reset_val_o,
  input wire [7:0]  sp_reset_val_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // only writes while running are taken
  wire mode_wr = reg_wr_i && reg_addr_i == 8'h87 && !cpu_halt_o && !sys_reset_o;
  wire stp     = !osc_run_o;
  chk_idle_entry: assert property (mode_wr && reg_wdata_i == 8'h01 |=> ##1 cpu_halt_o && osc_run_o)
    else $error("idle not entered");
  chk_stop_entry: assert property (mode_wr && reg_wdata_i == 8'h03 |=> ##1 stp)
    else $error("stop not entered");
  chk_other_run: assert property (mode_wr && reg_wdata_i != 8'h01 && reg_wdata_i != 8'h03
    |=> ##1 !cpu_halt_o)
    else $error("halted on a non-mode code");
  chk_stop_clocks: assert property (stp |-> !sys_clk_en_o && !periph_clk_en_o && cpu_halt_o)
    else $error("clocks run in stop");
  chk_stop_units: assert property (stp |-> !interval_timer_run_o && !converter_run_o
    && !tone_output_unit_run_o && watchdog_timer_run_o == watchdog_rc_oscillator_sel_i)
    else $error("unit runs in stop");
  chk_sub_clock: assert property (stp |-> watch_timer_en_o == sub_clock_running_i
    && display_en_o == sub_clock_running_i)
    else $error("watch or display gating wrong");
  chk_event_timers: assert property (timer_run_o == (stp ? timer_event_mode_i : 5'h1F))
    else $error("timer gating wrong");
  chk_stab_pulse: assert property (stab_start_o |-> osc_run_o && cpu_halt_o ##1 !stab_start_o)
    else $error("stabilisation start wrong");
  chk_reset_vals: assert property (sys_reset_o |-> pc_reset_val_o == 16'h0000
    && sp_reset_val_o == 8'h07)
    else $error("reset values wrong");
endmodule
bind pdrc_ctrl pdrc_checker pdrc_checker_i (.*);

// *** tb/pdrc_cpu_model.sv ***
// pdrc_cpu_model.sv: interrupt line and interval timer standing beside the controller
// assumes the bench commands the wake request; one clock
`timescale 1ns/1ps
module pdrc_cpu_model #(
  parameter STAB = 6
) (
  input  wire       clk_i,
  input  wire       stab_start_o,
  input  wire       wake_req,
  output wire [7:0] irq_pending_i,
  output reg        interval_timer_ovf_i = 1'b0
);
  integer cnt = 0;
  assign irq_pending_i = wake_req ? 8'h04 : 8'h00;
  always @(posedge clk_i)
  begin
    interval_timer_ovf_i <= (cnt == 1);
    if (stab_start_o)
      cnt <= STAB;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule

// *** tb/pdrc_ctrl_bench.sv ***
// pdrc_ctrl_bench.sv: register-driven tests of the power/reset controller
// assumes 40 MHz clock and short filter and power-up counts
`timescale 1ns/1ps
module pdrc_ctrl_bench;
  logic clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, wake_req = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, irq_enable_i = 8'h00;
  logic external_reset_pin_n_i = 1, watchdog_overflow_i = 0, watchdog_enable_bit_i = 0;
  logic low_voltage_detect_i = 0, low_voltage_reset_enable_bit_i = 0;
  logic on_chip_debugger_reset_i = 0, global_interrupt_enable_i = 0, serial_ext_clk_i = 0;
  logic sub_clock_running_i = 0, watchdog_rc_oscillator_sel_i = 0;
  logic [4:0] timer_event_mode_i = 5'h00;
  logic [1:0] universal_serial_units_ext_clk_i = 2'h0;
  wire [7:0] irq_pending_i, reg_rdata_o, acc_reset_val_o, sp_reset_val_o;
  wire [15:0] pc_reset_val_o;
  wire [4:0] timer_run_o;
  wire [1:0] universal_serial_units_run_o;
  wire interval_timer_ovf_i, cpu_halt_o, sys_reset_o, irq_vector_o, resume_next_o, osc_run_o;
  wire sys_clk_en_o, periph_clk_en_o, watch_timer_en_o, display_en_o, serial_run_o;
  wire interval_timer_run_o, converter_run_o, tone_output_unit_run_o, watchdog_timer_run_o;
  wire stab_start_o;
  integer miscompares = 0, checks_done = 0, i, j;
  logic saw_vec = 0, saw_res = 0, saw_stab = 0;
  pdrc_ctrl #(.FILT_CYC(4), .POR_CYC(4)) pdrc_ctrl_i (.*);
  pdrc_cpu_model pdrc_cpu_model_i (.*);
  always #12.5 clk_i = ~clk_i;
  // wake pulses last one cycle, so they are caught sticky
  always @(posedge clk_i)
  begin
    saw_vec <= saw_vec | irq_vector_o;
    saw_res <= saw_res | resume_next_o;
    saw_stab <= saw_stab | stab_start_o;
  end
  task chk(input string what, input [15:0] seen, input [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1;
    @(posedge clk_i);
    reg_wr_i <= 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1 chk("rdata", reg_rdata_o, e);
  endtask
  // sel 1 waits on reset, 0 on halt
  task wait_low(input sel);
    i = 0;
    while ((sel ? sys_reset_o : cpu_halt_o) !== 1'b0 && i < 60)
    begin
      tick(1);
      i = i + 1;
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    tick(5);
    rst_b_i <= 1;
    wait_low(1);
    chk("resets", {acc_reset_val_o, sp_reset_val_o}, 16'h0007);
    chk("pclk", periph_clk_en_o, 1);
    rd(8'h87, 8'h00);
    rd(8'hF0, 8'h00);
    for (j = 0; j < 4; j++)
    begin
      wr(8'h87, 8'h02 << j);
      tick(3);
      chk("halt", cpu_halt_o, 0);
      rd(8'h87, 8'h02 << j);
    end
    irq_enable_i <= 8'h04;
    global_interrupt_enable_i <= 1;
    wr(8'h87, 8'h01);
    tick(3);
    chk("idle", {cpu_halt_o, osc_run_o, periph_clk_en_o, timer_run_o}, 16'hFF);
    wake_req <= 1;
    wait_low(0);
    wake_req <= 0;
    tick(1);
    chk("vec", {saw_vec, saw_res}, 2'h2);
    rd(8'h87, 8'h00);
    global_interrupt_enable_i <= 0;
    irq_enable_i <= 8'h01;
    sub_clock_running_i <= 1;
    timer_event_mode_i <= 5'h15;
    universal_serial_units_ext_clk_i <= 2'h2;
    wr(8'h87, 8'h03);
    tick(3);
    chk("clk", {osc_run_o, sys_clk_en_o, periph_clk_en_o}, 3'h0);
    chk("tmr", timer_run_o, 5'h15);
    chk("sub", {watch_timer_en_o, display_en_o}, 2'h3);
    chk("usu", universal_serial_units_run_o, 2'h2);
    chk("spi", serial_run_o, 0);
    rd(8'h87, 8'h03);
    wake_req <= 1;
    tick(8);
    chk("held", cpu_halt_o, 1);
    irq_enable_i <= 8'h04;
    wait_low(0);
    wake_req <= 0;
    tick(1);
    chk("wake", {saw_stab, saw_res}, 2'h3);
    rd(8'h87, 8'h00);
    wr(8'h87, 8'h05);
    external_reset_pin_n_i <= 0;
    tick(3);
    external_reset_pin_n_i <= 1;
    tick(3);
    chk("glitch", sys_reset_o, 0);
    external_reset_pin_n_i <= 0;
    tick(8);
    chk("pin", sys_reset_o, 1);
    external_reset_pin_n_i <= 1;
    wait_low(1);
    rd(8'h87, 8'h00);
    watchdog_overflow_i <= 1;
    tick(3);
    chk("wdoff", sys_reset_o, 0);
    watchdog_enable_bit_i <= 1;
    low_voltage_reset_enable_bit_i <= 1;
    for (j = 0; j < 3; j++)
    begin
      {on_chip_debugger_reset_i, watchdog_overflow_i, low_voltage_detect_i} <= 3'h1 << j;
      tick(3);
      chk("source", sys_reset_o, 1);
      {on_chip_debugger_reset_i, watchdog_overflow_i, low_voltage_detect_i} <= 3'h0;
      wait_low(1);
    end
    rd(8'h89, 8'h20);
    summarize;
  end
  initial
  begin
    #100000;
    miscompares = miscompares + 1;
    summarize;
  end
endmodule
